/* rir_consts.svh */
/*
 Register offsets, field positions, reset values and fixed counts of the
 reader interrupt, FIFO status and receive length register bank.
 Assumes inclusion by its bare name from the design files.
*/
`ifndef RIR_CONSTS_SVH
`define RIR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RIR_ADDR_IRQ2 6'h38
`define RIR_ADDR_FIFO_STAT 6'h39
`define RIR_ADDR_RXLEN_UP 6'h3A

// ----------------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------------
`define RIR_IRQ2_ANA 7
`define RIR_IRQ2_CMD 6
`define RIR_IRQ2_CRC 2
`define RIR_IRQ2_LEN 1
`define RIR_IRQ2_PRE 0
`define RIR_IRQ2_RESET 8'h00
`define RIR_IRQ2_IMPL_MASK 8'hC7
`define RIR_FST_TX 7
`define RIR_FST_RX 6
`define RIR_FST_OVF 5
`define RIR_RXL_NOCRC 7
`define RIR_RXL_RAW 6
`define RIR_RXL_REP 5
`define RIR_RXL_AUTO 4
`define RIR_RXL_RESET 8'h00
`define RIR_FIFO_DEPTH 24
`define RIR_FB_EMPTY_READ 5'h1F
`define RIR_ERRCODE_LEN 12'h029

`endif

/* rir_pkg.sv */
/*
 Types shared by the reader status register bank.
 Assumes nothing of its surroundings.
*/
package rir_pkg;
    typedef enum logic [1:0] {
        RIR_RX_IDLE = 2'b00,
        RIR_RX_HDR = 2'b01,
        RIR_RX_DATA = 2'b10
    } rir_rx_state_t;
    typedef logic [11:0] rir_rxlen_t;
endpackage

/* rir_fifo_if.sv */
/*
 Interface between the register bank and its FIFO occupancy tracker.
 Assumes both ends run on mclk.
*/
`timescale 1ns/1ps
interface rir_fifo_if;
    logic push;
    logic pop;
    logic clear;
    logic ovf_pulse;
    logic overflow;
    logic [4:0] count;
    modport track(input push, input pop, input clear,
                  output ovf_pulse, output overflow, output count);
    modport ctrl(output push, output pop, output clear,
                 input ovf_pulse, input overflow, input count);
endinterface

/* rir_sync2.sv */
/*
 Two-flop synchroniser with any-edge detection, one bit per lane.
 Assumes asynchronous inputs and a single clock mclk.
*/
`timescale 1ns/1ps
module rir_sync2 #(
    parameter int WIDTH = 4
) (
    input wire logic mclk, // Block clock
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic [WIDTH-1:0] async_in, // Pins from outside the domain
    output logic [WIDTH-1:0] level_out, // Synchronised level
    output logic [WIDTH-1:0] edge_out // One-cycle pulse on either edge
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("rir_sync2 needs at least one lane");
        end
    endgenerate

    // Edge is taken between the second and third stage, never the first
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            meta <= async_in;
            stage2 <= meta;
            stage3 <= stage2;
        end
    end

    assign level_out = stage2;
    assign edge_out = stage2 ^ stage3;
endmodule

/* rir_fifo_track.sv */
/*
 Byte occupancy tracker of the active FIFO: count, overflow, empty read.
 Assumes push and pop strobes on mclk, at most one of each per cycle.
*/
`timescale 1ns/1ps
`include "rir_consts.svh"
module rir_fifo_track
    import rir_pkg::*;
#(
    parameter int DEPTH = `RIR_FIFO_DEPTH
) (
    input wire logic mclk, // Block clock
    input wire logic blk_rst, // Reset or chip disabled, high
    rir_fifo_if.track bus // Strobes in, status out
);
    localparam logic [4:0] DEPTH_W = 5'(DEPTH);
    logic [4:0] count;
    logic empty_read;
    logic push_only;

    generate
        // Code 1Fh is reserved for the empty-read marker
        if (DEPTH < 1 || DEPTH > 30) begin : g_bad_depth
            $error("rir_fifo_track depth must lie in 1..30");
        end
    endgenerate

    assign push_only = bus.push && !bus.pop;
    assign bus.ovf_pulse = push_only && (count == DEPTH_W); // [R12]

    always_ff @(posedge mclk) begin
        if (blk_rst || bus.clear) begin
            count <= 5'h00;
        end else if (push_only && count != DEPTH_W) begin
            count <= count + 5'h01;
        end else if (bus.pop && !bus.push && count != 5'h00) begin
            count <= count - 5'h01;
        end
    end

    // Set wins over a clear in the same cycle, so no overflow goes unseen
    always_ff @(posedge mclk) begin
        if (blk_rst) begin
            bus.overflow <= 1'b0;
        end else if (bus.ovf_pulse) begin
            bus.overflow <= 1'b1; // [R12]
        end else if (bus.clear) begin
            bus.overflow <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (blk_rst) begin
            empty_read <= 1'b0;
        end else if (bus.pop && !bus.push && count == 5'h00) begin
            empty_read <= 1'b1; // [R13]
        end else if (bus.clear || bus.push) begin
            empty_read <= 1'b0;
        end
    end

    assign bus.count = empty_read ? `RIR_FB_EMPTY_READ : count; // [R13]

    default clocking cb @(posedge mclk); endclocking
    default disable iff (blk_rst);

    count_bound_a: assert property (count <= DEPTH_W) // [R12]
        else $error("fifo byte count above depth");
    empty_mark_a: assert property (
        bus.pop && !bus.push && !bus.clear && count == 5'h00 |=>
        bus.count == `RIR_FB_EMPTY_READ) // [R13]
        else $error("empty read not marked");
endmodule

/* rir_status_regs.sv */
/*
 Interrupt status two, FIFO status and receive length upper registers of
 the reader, with the interrupt pin. Assumes the register port strobes and
 receiver/transmitter events arrive on mclk; status pins are asynchronous.
*/
// Functional notes
// R1 - Analog change flag bit 7 sets on any edge of oscillator, lock, field.
// R2 - Command done flag bit 6 sets when a direct command finishes.
// R3 - Bit 1 sets on short reception or protocol violation.
// R4 - Bit 0 sets on preamble failure or FIFO overflow.
// R5 - Each error sets its sub-flag and the summary error; CRC uses bit 2.
// R6 - Status two is zero at reset and while chip enable is low.
// R7 - A completed read of status two clears it.
// R8 - Interrupt pin high while any enabled flag in either register is set.
// R9 - Host may mask sub-flags and clear via first register only.
// R10 - FIFO status bit 7 shows transmission in progress.
// R11 - FIFO status bit 6 shows reception in progress.
// R12 - FIFO status bit 5 sets when more than 24 bytes are loaded.
// R13 - Five-bit count shows unread bytes; empty read shows 1Fh.
// R14 - Raw option bit 6 passes CRC to FIFO; header interrupt becomes second-byte.
// R15 - Repeat option bit 5 adds interrupts after fourth and sixth byte.
// R16 - Auto option bit 4 swaps expected length to 41 on header one.
// R17 - Host programs expected length: upper four bits here, low byte elsewhere.
// R18 - Flags set regardless of enables; enables only gate the pin.
// R19 - Reserved bits 5 to 3 read zero, never raise the pin.
`timescale 1ns/1ps
`include "rir_consts.svh"
module rir_status_regs
    import rir_pkg::*;
(
    input wire logic mclk, // Block clock, 20 MHz
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic chip_en, // Chip enable pin, asynchronous
    input wire logic osc_ok, // Oscillator good, asynchronous
    input wire logic pll_ok, // Synthesizer locked, asynchronous
    input wire logic rf_field_good, // RF field good, asynchronous
    input wire logic [5:0] reg_addr, // Register address
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe, end of read phase
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data, valid after reg_rd
    input wire logic [7:0] irq2_enable, // Enable bits for status two
    input wire logic irq1_pending, // Enabled flag pending in first register
    input wire logic [7:0] rx_length_lower, // Companion low length byte
    input wire logic cmd_done, // Direct command finished
    input wire logic crc_err, // CRC error seen
    input wire logic preamble_err, // Preamble detect failure
    input wire logic protocol_err, // Disabled command or protocol violation
    input wire logic tx_active, // Transmission in progress
    input wire logic rx_start, // Reception begins
    input wire logic rx_end, // Reception ends
    input wire logic [11:0] rx_bit_count, // Bits received at rx_end
    input wire logic hdr_valid, // Header bit strobe
    input wire logic hdr_bit, // Header bit value
    input wire logic rx_byte, // One byte received
    input wire logic fifo_push, // Byte loaded into FIFO
    input wire logic fifo_pop, // Byte read from FIFO
    input wire logic fifo_clear, // FIFO emptied
    output rir_rxlen_t expected_rx_length, // Length the receiver waits for
    output logic receive_without_crc, // Receive without CRC option
    output logic raw_fifo_second_byte_option, // CRC bytes also go to FIFO
    output logic header_interrupt, // Header-bit event pulse
    output logic second_byte_interrupt, // Second-byte event pulse
    output logic error_event, // Pulse to summary error flag
    output logic irq // Interrupt pin
);
    // ------------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------------
    logic [3:0] pin_level;
    logic [3:0] pin_edge;
    logic chip_en_s;
    logic ana_change;
    logic blk_rst;

    rir_sync2 #(.WIDTH(4)) u_pin_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in({chip_en, osc_ok, pll_ok, rf_field_good}),
        .level_out(pin_level),
        .edge_out(pin_edge)
    );

    assign chip_en_s = pin_level[3];
    assign ana_change = |pin_edge[2:0]; // [R1]
    assign blk_rst = sys_rst || !chip_en_s; // [R6]

    // ------------------------------------------------------------------------
    // FIFO tracker
    // ------------------------------------------------------------------------
    rir_fifo_if fifo_bus();

    rir_fifo_track #(.DEPTH(`RIR_FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .blk_rst(blk_rst),
        .bus(fifo_bus.track)
    );

    assign fifo_bus.push = fifo_push;
    assign fifo_bus.pop = fifo_pop;
    // A new reception starts from an empty FIFO
    assign fifo_bus.clear = fifo_clear || rx_start;

    // ------------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------------
    logic [7:0] irq2;
    logic [7:0] rx_len_up;
    logic [7:0] irq2_set;
    logic rd_irq2;
    logic wr_rxlen;

    assign rd_irq2 = reg_rd && reg_addr == `RIR_ADDR_IRQ2;
    assign wr_rxlen = reg_wr && reg_addr == `RIR_ADDR_RXLEN_UP;

    always_ff @(posedge mclk) begin
        if (blk_rst) begin
            rx_len_up <= `RIR_RXL_RESET;
        end else if (wr_rxlen) begin
            rx_len_up <= reg_wdata; // [R15] [R17]
        end
    end

    assign receive_without_crc = rx_len_up[`RIR_RXL_NOCRC];
    assign raw_fifo_second_byte_option = rx_len_up[`RIR_RXL_RAW]; // [R14]

    // ------------------------------------------------------------------------
    // Reception tracking
    // ------------------------------------------------------------------------
    rir_rx_state_t rx_state;
    rir_rx_state_t next_rx_state;
    logic rx_active;
    logic err_code_mode;
    logic hdr_one;
    logic [2:0] rx_bytes;
    logic [2:0] next_rx_bytes;
    rir_rxlen_t exp_len;
    logic short_rx;

    assign rx_active = rx_state != RIR_RX_IDLE;
    assign hdr_one = rx_state == RIR_RX_HDR && hdr_valid && hdr_bit;

    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            RIR_RX_IDLE: begin
                if (rx_start) begin
                    next_rx_state = RIR_RX_HDR;
                end
            end
            RIR_RX_HDR: begin
                if (rx_end) begin
                    next_rx_state = RIR_RX_IDLE;
                end else if (hdr_valid) begin
                    next_rx_state = RIR_RX_DATA;
                end
            end
            RIR_RX_DATA: begin
                if (rx_end) begin
                    next_rx_state = RIR_RX_IDLE;
                end
            end
            default: begin
                next_rx_state = RIR_RX_IDLE;
            end
        endcase
        if (rx_start) begin
            next_rx_state = RIR_RX_HDR;
        end
    end

    always_ff @(posedge mclk) begin
        if (blk_rst) begin
            rx_state <= RIR_RX_IDLE;
        end else begin
            rx_state <= next_rx_state;
        end
    end

    // Error-code length stays until the next reception, so a late read agrees
    always_ff @(posedge mclk) begin
        if (blk_rst || rx_start) begin
            err_code_mode <= 1'b0;
        end else if (hdr_one && rx_len_up[`RIR_RXL_AUTO]) begin
            err_code_mode <= 1'b1; // [R16]
        end
    end

    assign exp_len = err_code_mode ? `RIR_ERRCODE_LEN
                                   : {rx_len_up[3:0], rx_length_lower}; // [R16] [R17]
    assign short_rx = rx_end && rx_active && rx_bit_count < exp_len; // [R3]

    always_ff @(posedge mclk) begin
        if (blk_rst) begin
            expected_rx_length <= 12'h000;
        end else begin
            expected_rx_length <= exp_len;
        end
    end

    // Byte count saturates at seven; only the second, fourth and sixth matter
    assign next_rx_bytes = (rx_bytes == 3'h7) ? rx_bytes : rx_bytes + 3'h1;

    always_ff @(posedge mclk) begin
        if (blk_rst || rx_start) begin
            rx_bytes <= 3'h0;
        end else if (rx_byte && rx_active) begin
            rx_bytes <= next_rx_bytes;
        end
    end

    always_ff @(posedge mclk) begin
        if (blk_rst) begin
            header_interrupt <= 1'b0;
            second_byte_interrupt <= 1'b0;
        end else begin
            header_interrupt <= hdr_one && !rx_len_up[`RIR_RXL_RAW]; // [R14]
            second_byte_interrupt <= rx_len_up[`RIR_RXL_RAW] && rx_byte && rx_active &&
                (next_rx_bytes == 3'h2 || (rx_len_up[`RIR_RXL_REP] &&
                (next_rx_bytes == 3'h4 || next_rx_bytes == 3'h6))); // [R14] [R15]
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status two
    // ------------------------------------------------------------------------
    always_comb begin
        irq2_set = 8'h00;
        irq2_set[`RIR_IRQ2_ANA] = ana_change; // [R1] [R18]
        irq2_set[`RIR_IRQ2_CMD] = cmd_done; // [R2]
        irq2_set[`RIR_IRQ2_CRC] = crc_err; // [R5]
        irq2_set[`RIR_IRQ2_LEN] = short_rx || protocol_err; // [R3]
        irq2_set[`RIR_IRQ2_PRE] = preamble_err || fifo_bus.ovf_pulse; // [R4]
    end

    // An event in the clearing read cycle survives the clear
    always_ff @(posedge mclk) begin
        if (blk_rst) begin
            irq2 <= `RIR_IRQ2_RESET; // [R6]
        end else if (rd_irq2) begin
            irq2 <= irq2_set & `RIR_IRQ2_IMPL_MASK; // [R7] [R19]
        end else begin
            irq2 <= (irq2 | irq2_set) & `RIR_IRQ2_IMPL_MASK; // [R18]
        end
    end

    always_ff @(posedge mclk) begin
        if (blk_rst) begin
            error_event <= 1'b0;
        end else begin
            error_event <= |irq2_set[2:0]; // [R5]
        end
    end

    // First-register flags arrive already gated by their own enables
    always_ff @(posedge mclk) begin
        if (blk_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq2 & irq2_enable & `RIR_IRQ2_IMPL_MASK) || irq1_pending; // [R8] [R9]
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `RIR_ADDR_IRQ2: reg_rdata <= irq2;
                `RIR_ADDR_FIFO_STAT: reg_rdata <= {tx_active, rx_active,
                    fifo_bus.overflow, fifo_bus.count}; // [R10] [R11] [R12] [R13]
                `RIR_ADDR_RXLEN_UP: reg_rdata <= rx_len_up;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (blk_rst);

    ana_edge_a: assert property (ana_change |=> irq2[`RIR_IRQ2_ANA]) // [R1]
        else $error("analog change not flagged");
    cmd_flag_a: assert property (cmd_done |=> irq2[`RIR_IRQ2_CMD]) // [R2]
        else $error("command done not flagged");
    short_rx_a: assert property (short_rx |=> irq2[`RIR_IRQ2_LEN] && error_event) // [R3]
        else $error("short reception not flagged");
    ovf_error_a: assert property (fifo_bus.ovf_pulse |=>
        irq2[`RIR_IRQ2_PRE] && fifo_bus.overflow) // [R4]
        else $error("overflow not flagged");
    crc_summary_a: assert property (crc_err |=> irq2[`RIR_IRQ2_CRC] && error_event) // [R5]
        else $error("crc error without summary");
    read_clear_a: assert property (rd_irq2 && irq2_set == 8'h00 |=>
        irq2 == 8'h00 && reg_rdata == $past(irq2)) // [R7]
        else $error("status two not cleared by read");
    irq_pin_a: assert property (##1 irq ==
        $past(|(irq2 & irq2_enable) || irq1_pending)) // [R8]
        else $error("interrupt pin mismatch");
    rsvd_zero_a: assert property (irq2[5:3] == 3'h0) // [R19]
        else $error("reserved bits set");
    rx_status_a: assert property (reg_rd && reg_addr == `RIR_ADDR_FIFO_STAT |=>
        reg_rdata[`RIR_FST_RX] == $past(rx_active) &&
        reg_rdata[`RIR_FST_TX] == $past(tx_active)) // [R10] [R11]
        else $error("activity bits wrong");
    auto_len_a: assert property (hdr_one && rx_len_up[`RIR_RXL_AUTO] && !rx_start |=>
        ##1 expected_rx_length == `RIR_ERRCODE_LEN) // [R16]
        else $error("error code length not applied");
    disable_clear_a: assert property (disable iff (sys_rst)
        !chip_en_s |=> irq2 == 8'h00) // [R6]
        else $error("status two kept while disabled");

    cmd_read_c: cover property (cmd_done ##[1:20] rd_irq2);
    second_byte_c: cover property (second_byte_interrupt ##[1:40] second_byte_interrupt);
    overflow_c: cover property (fifo_bus.ovf_pulse);
    irq_release_c: cover property (irq ##1 rd_irq2 ##2 !irq);
endmodule

/* rir_host_model.sv */
/*
 Host microcontroller model that drives the register port of the status bank.
 Assumes the bank samples its strobes on the rising edge of mclk.
*/
`timescale 1ns/1ps
module rir_host_model (
    input wire logic mclk, // Block clock
    output logic [5:0] reg_addr, // Register address
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    output logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata // Read data
);
    initial begin
        reg_addr = 6'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // Upper length nibble and options go here, the low byte lives elsewhere
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // Read data stands one edge after the strobe edge
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        #1 d = reg_rdata;
    endtask
endmodule

/* tb_top.sv */
/*
 Self-checking bench of the reader status register bank.
 Assumes the host model and the design files are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
    import rir_pkg::*;
    logic mclk, sys_rst, chip_en, osc_ok, pll_ok, rf_field_good, irq1_pending;
    logic [5:0] reg_addr;
    logic reg_wr, reg_rd, tx_active, hdr_bit;
    logic [7:0] reg_wdata, reg_rdata, irq2_enable, rx_length_lower;
    logic [11:0] rx_bit_count;
    logic [10:0] pl;
    rir_rxlen_t expected_rx_length;
    logic receive_without_crc, raw_fifo_second_byte_option;
    logic header_interrupt, second_byte_interrupt, error_event, irq;
    int mismatches, samples_checked, hdr_cnt, sb_cnt, err_cnt;

    rir_host_model u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    rir_status_regs u_dut (.mclk(mclk), .sys_rst(sys_rst), .chip_en(chip_en),
        .osc_ok(osc_ok), .pll_ok(pll_ok), .rf_field_good(rf_field_good),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .irq2_enable(irq2_enable), .irq1_pending(irq1_pending),
        .rx_length_lower(rx_length_lower), .cmd_done(pl[0]), .crc_err(pl[1]),
        .preamble_err(pl[2]), .protocol_err(pl[3]), .tx_active(tx_active),
        .rx_start(pl[4]), .rx_end(pl[5]), .rx_bit_count(rx_bit_count),
        .hdr_valid(pl[6]), .hdr_bit(hdr_bit), .rx_byte(pl[7]), .fifo_push(pl[8]),
        .fifo_pop(pl[9]), .fifo_clear(pl[10]), .expected_rx_length(expected_rx_length),
        .receive_without_crc(receive_without_crc),
        .raw_fifo_second_byte_option(raw_fifo_second_byte_option),
        .header_interrupt(header_interrupt), .second_byte_interrupt(second_byte_interrupt),
        .error_event(error_event), .irq(irq));

    // ------------------------------------------------------------------------
    // Clock, pulse counters and shared tasks
    // ------------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (header_interrupt === 1'b1) hdr_cnt++;
        if (second_byte_interrupt === 1'b1) sb_cnt++;
        if (error_event === 1'b1) err_cnt++;
    end
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(a, d);
        chk($sformatf("register %h", a), {4'h0, exp}, {4'h0, d});
    endtask
    // Event strobes are one cycle wide; an edge passes before the next one
    task automatic pulse(input int b);
        @(posedge mclk);
        pl[b] <= 1'b1;
        @(posedge mclk);
        pl <= '0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic complete_run;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset;
        rdchk(6'h38, 8'h00);
        rdchk(6'h3A, 8'h00);
        pulse(0);
        @(posedge mclk) chip_en <= 1'b0;
        cyc(4);
        @(posedge mclk) chip_en <= 1'b1;
        cyc(4);
        rdchk(6'h38, 8'h00);
        u_host.wr(6'h38, 8'hFF);
        rdchk(6'h38, 8'h00);
    endtask
    task automatic t_events;
        int src[4] = '{0, 1, 2, 3};
        logic [7:0] exp[4] = '{8'h40, 8'h04, 8'h01, 8'h02};
        for (int i = 0; i < 4; i++) begin
            pulse(src[i]);
            rdchk(6'h38, exp[i]);
            rdchk(6'h38, 8'h00);
        end
    endtask
    task automatic t_irq;
        @(posedge mclk) irq2_enable <= 8'h00;
        pulse(0);
        cyc(2);
        chk("irq masked", 12'h000, {11'h0, irq});
        @(posedge mclk) irq2_enable <= 8'h40;
        cyc(2);
        chk("irq enabled", 12'h001, {11'h0, irq});
        rdchk(6'h38, 8'h40);
        cyc(1);
        chk("irq after read", 12'h000, {11'h0, irq});
        @(posedge mclk) irq2_enable <= 8'h38;
        cyc(3);
        chk("irq reserved", 12'h000, {11'h0, irq});
        @(posedge mclk) irq1_pending <= 1'b1;
        cyc(2);
        chk("irq first reg", 12'h001, {11'h0, irq});
        @(posedge mclk) irq1_pending <= 1'b0;
        irq2_enable <= 8'h00;
        cyc(2);
        // Sub-flag masking: releasing the first register frees the pin
        pulse(1);
        @(posedge mclk) irq1_pending <= 1'b1;
        cyc(2);
        chk("irq summary", 12'h001, {11'h0, irq});
        @(posedge mclk) irq1_pending <= 1'b0;
        cyc(2);
        chk("irq sub masked", 12'h000, {11'h0, irq});
        rdchk(6'h38, 8'h04);
    endtask
    task automatic t_analog;
        @(posedge mclk) osc_ok <= 1'b1;
        cyc(6);
        rdchk(6'h38, 8'h80);
        @(posedge mclk) osc_ok <= 1'b0;
        cyc(6);
        rdchk(6'h38, 8'h80);
        @(posedge mclk) pll_ok <= 1'b1;
        cyc(6);
        rdchk(6'h38, 8'h80);
        @(posedge mclk) rf_field_good <= 1'b1;
        cyc(6);
        rdchk(6'h38, 8'h80);
    endtask
    task automatic t_fifo;
        repeat (25) pulse(8);
        rdchk(6'h39, 8'h38);
        rdchk(6'h38, 8'h01);
        pulse(10);
        pulse(9);
        @(posedge mclk) tx_active <= 1'b1;
        rdchk(6'h39, 8'h9F);
        @(posedge mclk) tx_active <= 1'b0;
    endtask
    task automatic t_rx;
        @(posedge mclk) rx_length_lower <= 8'h10;
        rx_bit_count <= 12'h008;
        u_host.wr(6'h3A, 8'h80);
        cyc(1);
        chk("no crc option", 12'h001, {11'h0, receive_without_crc});
        rdchk(6'h3A, 8'h80);
        pulse(4);
        rdchk(6'h39, 8'h40);
        pulse(5);
        rdchk(6'h38, 8'h02);
        rdchk(6'h39, 8'h00);
        u_host.wr(6'h3A, 8'h60);
        cyc(1);
        chk("raw option", 12'h001, {11'h0, raw_fifo_second_byte_option});
        pulse(4);
        @(posedge mclk) hdr_bit <= 1'b1;
        pulse(6);
        repeat (6) pulse(7);
        cyc(2);
        chk("second byte pulses", 12'd3, sb_cnt[11:0]);
        chk("header pulses raw", 12'd0, hdr_cnt[11:0]);
        u_host.wr(6'h3A, 8'h10);
        pulse(4);
        pulse(6);
        cyc(3);
        chk("error code length", 12'd41, expected_rx_length);
        chk("header pulses", 12'd1, hdr_cnt[11:0]);
        @(posedge mclk) rx_bit_count <= 12'd41;
        pulse(5);
        rdchk(6'h38, 8'h00);
        chk("error events", 12'd6, err_cnt[11:0]);
    endtask

    // ------------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        chip_en = 1'b1;
        {osc_ok, pll_ok, rf_field_good, irq1_pending, tx_active, hdr_bit} = '0;
        irq2_enable = 8'h00;
        rx_length_lower = 8'h00;
        rx_bit_count = 12'h000;
        pl = '0;
        cyc(3);
        sys_rst <= 1'b0;
        cyc(4);
        t_reset();
        t_events();
        t_irq();
        t_analog();
        t_fifo();
        t_rx();
        complete_run();
    end
    // The sequence needs well under 1000 cycles; this leaves a wide margin
    initial begin
        cyc(20000);
        mismatches++;
        complete_run();
    end
endmodule
